// ### hw/capture_edge_detect.sv
// input synchroniser and edge detector for the capture pin
`timescale 1ns/1ps
module capture_edge_detect
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic pinIn,
  output logic riseEvent,
  output logic fallEvent
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic sync1_next;
  logic sync2_next;
  logic last_next;

  // two-stage synchroniser, then one more stage for edge history
  always_comb
  begin
    sync1_next = pinIn;
    sync2_next = sync1_reg;
    last_next = sync2_reg;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg <= last_next;
    end
  end

  assign riseEvent = sync2_reg & ~last_reg;
  assign fallEvent = ~sync2_reg & last_reg;
endmodule // capture_edge_detect

// ### hw/capture_pkg.sv
// types shared by the capture channel
package capture_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_BOTH = 3'h1, MODE_FALL = 3'h2, MODE_RISE = 3'h3,
    MODE_PRE4 = 3'h4, MODE_PRE16 = 3'h5, MODE_UNUSED = 3'h6, MODE_WAKE = 3'h7
  } capture_mode_t;
  typedef enum logic [2:0] {
    TB_TIMER_THREE = 3'h0, TB_TIMER_TWO = 3'h1, TB_TIMER_FOUR = 3'h2,
    TB_TIMER_FIVE = 3'h3, TB_TIMER_ONE = 3'h4, TB_RES_A = 3'h5, TB_RES_B = 3'h6,
    TB_PERIPHERAL = 3'h7
  } timebase_sel_t;
endpackage

// ### hw/capture_regs.svh
// register offsets, field positions and reset values of the capture channel
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH
`define CTRL_ONE_OFFSET 12'h000
`define CAPTURE_DATA_OFFSET 12'h004
`define CTRL_ONE_RESET 16'h0000
`define CTRL_ONE_WMASK 16'h3c67
`define IDLE_STOP_BIT 13
`define TBSEL_HI 12
`define TBSEL_LO 10
`define CPI_HI 6
`define CPI_LO 5
`define OVF_BIT 4
`define BNE_BIT 3
`define MODE_HI 2
`define MODE_LO 0
`define BUF_DEPTH 4
`endif

// ### hw/input_capture_control.sv
// input capture channel with apb register access
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "capture_regs.svh"

// Summary of operation
// - idle-stop bit set halts capturing in CPU idle; clear keeps it running
// - timebase code 111 picks peripheral clock; 110 and 101 are reserved
// - codes 100,011,010,001,000 pick timers one, five, four, two, three
// - captures-per-interrupt field: interrupt every 1st, 2nd, 3rd or 4th capture
// - captures-per-interrupt field ignored in both-edge and wake modes
// - overflow flag read-only, set by hardware on buffer overflow
// - not-empty flag read-only, one while a capture is waiting
// - mode 111 only a rising-edge wake pin in sleep and idle
// - mode 110 leaves channel disabled
// - mode 101 captures every sixteenth rising edge
// - mode 100 captures every fourth rising edge
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 captures every rising and falling edge
// - mode 000 turns channel off
// - unimplemented control bits ignore writes and read zero
module input_capture_control
#(
  parameter int TIMER_WIDTH = 16,
  parameter int DEPTH = `BUF_DEPTH
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic captureChannel,
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  input wire logic [TIMER_WIDTH-1:0] timerOneClock,
  input wire logic [TIMER_WIDTH-1:0] timerTwoClock,
  input wire logic [TIMER_WIDTH-1:0] timerThreeClock,
  input wire logic [TIMER_WIDTH-1:0] timerFourClock,
  input wire logic [TIMER_WIDTH-1:0] timerFiveClock,
  input wire logic [TIMER_WIDTH-1:0] peripheralClock,
  output logic captureIrq
);
  import capture_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic riseEvent;
  logic fallEvent;
  logic cpuIdleS1_reg;
  logic cpuIdleS2_reg;
  logic cpuSleepS1_reg;
  logic cpuSleepS2_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [TIMER_WIDTH-1:0] buf_reg [DEPTH];
  logic [TIMER_WIDTH-1:0] buf_next [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] wrPtr_next;
  logic [PW-1:0] rdPtr_reg;
  logic [PW-1:0] rdPtr_next;
  logic [PW:0] count_reg;
  logic [PW:0] count_next;
  logic ovf_reg;
  logic ovf_next;
  logic [3:0] pre_reg;
  logic [3:0] pre_next;
  logic [1:0] cad_reg;
  logic [1:0] cad_next;
  logic irq_reg;
  logic irq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ready_reg;
  logic ready_next;
  logic err_reg;
  logic err_next;
  capture_mode_t mode;
  timebase_sel_t tbSel;
  logic [TIMER_WIDTH-1:0] stamp;
  logic running;
  logic captureEvent;
  logic setup;
  logic readData;
  logic writeCtrl;
  logic push;
  logic pop;

  // pin sync lives in the leaf; cpu state lines are synchronised here
  capture_edge_detect edgeDetect (
    .clock(clock),
    .resetn(resetn),
    .pinIn(captureChannel),
    .riseEvent(riseEvent),
    .fallEvent(fallEvent)
  );

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cpuIdleS1_reg <= 1'b0;
      cpuIdleS2_reg <= 1'b0;
      cpuSleepS1_reg <= 1'b0;
      cpuSleepS2_reg <= 1'b0;
    end
    else
    begin
      cpuIdleS1_reg <= cpuIdle;
      cpuIdleS2_reg <= cpuIdleS1_reg;
      cpuSleepS1_reg <= cpuSleep;
      cpuSleepS2_reg <= cpuSleepS1_reg;
    end
  end

  // timebase mux; reserved codes give zero rather than a stale timer
  function automatic logic [TIMER_WIDTH-1:0] pick_timebase(input timebase_sel_t sel);
    case (sel)
      TB_PERIPHERAL: pick_timebase = peripheralClock;
      TB_TIMER_ONE: pick_timebase = timerOneClock;
      TB_TIMER_FIVE: pick_timebase = timerFiveClock;
      TB_TIMER_FOUR: pick_timebase = timerFourClock;
      TB_TIMER_TWO: pick_timebase = timerTwoClock;
      TB_TIMER_THREE: pick_timebase = timerThreeClock;
      default: pick_timebase = '0;
    endcase
  endfunction

  // captures needed before one interrupt, less one
  function automatic logic [1:0] cadence_limit(input logic [1:0] cpi, input capture_mode_t m);
    if (m == MODE_BOTH || m == MODE_WAKE)
      cadence_limit = 2'h0;
    else
      cadence_limit = cpi;
  endfunction

  assign mode = capture_mode_t'(ctrl_reg[`MODE_HI:`MODE_LO]);
  assign tbSel = timebase_sel_t'(ctrl_reg[`TBSEL_HI:`TBSEL_LO]);
  // a process, not an assign, so the mux follows timer changes as well as the select
  always_comb
  begin
    stamp = pick_timebase(tbSel);
  end
  // idle halt only when the stop bit is set
  assign running = !(ctrl_reg[`IDLE_STOP_BIT] && cpuIdleS2_reg);

  // event qualification per mode
  always_comb
  begin
    pre_next = pre_reg;
    captureEvent = 1'b0;
    case (mode)
      MODE_BOTH: captureEvent = riseEvent | fallEvent;
      MODE_FALL: captureEvent = fallEvent;
      MODE_RISE: captureEvent = riseEvent;
      MODE_PRE4:
      begin
        if (riseEvent)
          pre_next = pre_reg + 4'h1;
        captureEvent = riseEvent && pre_reg[1:0] == 2'h3;
      end
      MODE_PRE16:
      begin
        if (riseEvent)
          pre_next = pre_reg + 4'h1;
        captureEvent = riseEvent && pre_reg == 4'hf;
      end
      default:
      begin
        // off, unused and wake: no capture, prescaler held clear
        pre_next = 4'h0;
        captureEvent = 1'b0;
      end
    endcase
    if (!running)
    begin
      pre_next = pre_reg;
      captureEvent = 1'b0;
    end
  end

  // apb decode; zero wait states, answer in the access cycle
  assign setup = psel && !penable;
  assign readData = psel && penable && !pwrite && paddr == `CAPTURE_DATA_OFFSET;
  assign writeCtrl = psel && penable && pwrite && paddr == `CTRL_ONE_OFFSET;
  assign push = captureEvent && count_reg != (PW+1)'(DEPTH);
  assign pop = readData && count_reg != '0;

  // capture buffer, status flags and interrupt cadence
  always_comb
  begin
    buf_next = buf_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    ovf_next = ovf_reg;
    cad_next = cad_reg;
    irq_next = 1'b0;
    if (push)
    begin
      buf_next[wrPtr_reg] = stamp;
      wrPtr_next = wrPtr_reg + PW'(1);
    end
    if (pop)
      rdPtr_next = rdPtr_reg + PW'(1);
    count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    // set beats drain in the same cycle
    if (captureEvent && count_reg == (PW+1)'(DEPTH))
      ovf_next = 1'b1;
    else if (count_next == '0)
      ovf_next = 1'b0;
    if (captureEvent)
    begin
      if (cad_reg >= cadence_limit(ctrl_reg[`CPI_HI:`CPI_LO], mode))
      begin
        cad_next = 2'h0;
        irq_next = 1'b1;
      end
      else
        cad_next = cad_reg + 2'h1;
    end
    // wake pin: rising edge interrupts only while cpu sleeps or idles
    if (mode == MODE_WAKE && riseEvent && (cpuSleepS2_reg || cpuIdleS2_reg))
      irq_next = 1'b1;
    if (mode == MODE_OFF || mode == MODE_UNUSED || mode == MODE_WAKE)
    begin
      // turning off discards stored captures
      wrPtr_next = '0;
      rdPtr_next = '0;
      count_next = '0;
      ovf_next = 1'b0;
      cad_next = 2'h0;
    end
  end

  // register write path and read mux
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (writeCtrl)
      ctrl_next = pwdata[15:0] & `CTRL_ONE_WMASK;
    ready_next = setup;
    err_next = setup && paddr != `CTRL_ONE_OFFSET && paddr != `CAPTURE_DATA_OFFSET;
    rdata_next = 32'h0;
    if (setup && !pwrite)
    begin
      if (paddr == `CTRL_ONE_OFFSET)
      begin
        rdata_next[15:0] = ctrl_reg & `CTRL_ONE_WMASK;
        rdata_next[`OVF_BIT] = ovf_next;
        rdata_next[`BNE_BIT] = count_next != '0;
      end
      else if (paddr == `CAPTURE_DATA_OFFSET)
        rdata_next[TIMER_WIDTH-1:0] = buf_reg[rdPtr_reg];
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= `CTRL_ONE_RESET;
      for (int i = 0; i < DEPTH; i++)
        buf_reg[i] <= '0;
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ovf_reg <= 1'b0;
      pre_reg <= 4'h0;
      cad_reg <= 2'h0;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      buf_reg <= buf_next;
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      pre_reg <= pre_next;
      cad_reg <= cad_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign captureIrq = irq_reg;

  property p_idle_halt;
    @(posedge clock) disable iff (!resetn)
    (ctrl_reg[`IDLE_STOP_BIT] && cpuIdleS2_reg) |-> !captureEvent;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("capture in halted idle");

  property p_peripheral_stamp;
    @(posedge clock) disable iff (!resetn)
    (push && tbSel == TB_PERIPHERAL) |=> buf_reg[$past(wrPtr_reg)] == $past(peripheralClock);
  endproperty
  a_peripheral_stamp: assert property (p_peripheral_stamp) else $error("bad stamp");

  property p_timer_one_stamp;
    @(posedge clock) disable iff (!resetn)
    (push && tbSel == TB_TIMER_ONE) |=> buf_reg[$past(wrPtr_reg)] == $past(timerOneClock);
  endproperty
  a_timer_one_stamp: assert property (p_timer_one_stamp) else $error("bad timer stamp");

  property p_every_capture_irq;
    @(posedge clock) disable iff (!resetn)
    (captureEvent && mode == MODE_RISE && ctrl_reg[`CPI_HI:`CPI_LO] == 2'h0) |=> captureIrq;
  endproperty
  a_every_capture_irq: assert property (p_every_capture_irq) else $error("irq missed");

  property p_both_ignores_cpi;
    @(posedge clock) disable iff (!resetn)
    (captureEvent && mode == MODE_BOTH) |=> captureIrq;
  endproperty
  a_both_ignores_cpi: assert property (p_both_ignores_cpi) else $error("cpi used");

  property p_overflow;
    @(posedge clock) disable iff (!resetn)
    (captureEvent && count_reg == (PW+1)'(DEPTH)) |=> ovf_reg;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_off_clears;
    @(posedge clock) disable iff (!resetn)
    (mode == MODE_OFF) |=> (count_reg == '0 && !ovf_reg);
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("off kept data");

  property p_fall_only;
    @(posedge clock) disable iff (!resetn)
    (mode == MODE_FALL && riseEvent) |-> !captureEvent;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rise captured");
endmodule // input_capture_control

// ### sim/capture_pin_model.sv
// external signal source that drives the capture input pin
`timescale 1ns/1ps
module capture_pin_model
(
  input wire logic clock,
  output logic pinLevel
);
  initial pinLevel = 1'b0;

  // each level is held six cycles so it clears the two-flop synchroniser
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clock);
      pinLevel <= 1'b1;
      repeat (6) @(posedge clock);
      pinLevel <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask
endmodule // capture_pin_model

// ### sim/input_capture_control_tb.sv
// self-checking testbench for the input capture channel
`timescale 1ns/1ps
module input_capture_control_tb;
  import capture_pkg::*;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin, err, captureIrq, cpuIdle = 0, cpuSleep = 0;
  logic [15:0] ev;
  logic [15:0] tm [0:5] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h7777};
  logic [15:0] stamp [0:7] = '{16'h3333, 16'h2222, 16'h4444, 16'h5555, 16'h1111,
    16'h0000, 16'h0000, 16'h7777};
  int pl [0:6] = '{2, 2, 2, 2, 8, 16, 2};
  int ex [0:6] = '{0, 4, 2, 2, 2, 1, 0};
  int mismatches = 0, tests_run = 0, irqCount = 0, cycles = 0, n, base;

  capture_pin_model pm (.clock(clock), .pinLevel(pin));
  input_capture_control uut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .captureChannel(pin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .timerOneClock(tm[0]), .timerTwoClock(tm[1]), .timerThreeClock(tm[2]),
    .timerFourClock(tm[3]), .timerFiveClock(tm[4]), .peripheralClock(tm[5]),
    .captureIrq(captureIrq));

  always #12.5 clock = ~clock;

  // irq pulses last one cycle, so count them at every edge; also cut a hang
  always @(posedge clock)
  begin
    cycles++;
    if (captureIrq === 1'b1) irqCount++;
    if (cycles == 40000)
    begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] ctl(logic idle, logic [2:0] tb, logic [1:0] cpi,
    capture_mode_t m);
    return {16'h0, 2'b0, idle, tb, 3'b0, cpi, 2'b0, m};
  endfunction

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] seen);
    tests_run++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // only the cycle ceiling ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pop captures while the not-empty flag reads one
  task automatic drain(output int c);
    c = 0;
    apb(0, 12'h000, 0);
    while (rd[3] === 1'b1 && c < 8)
    begin
      apb(0, 12'h004, 0);
      c++;
      apb(0, 12'h000, 0);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl reset", 32'h0, rd);
    apb(0, 12'h010, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1, 12'h000, 32'hffff);
    apb(0, 12'h000, 0);
    chk("ctrl mask", 32'h3c67, rd);
    // every timebase code; all timers step before each capture so a stale stamp shows
    for (int t = 0; t < 8; t++)
    begin
      apb(1, 12'h000, ctl(0, t[2:0], 0, MODE_RISE));
      for (int j = 0; j < 6; j++)
        tm[j] <= tm[j] + 16'h0001;
      pm.pulse(1);
      apb(0, 12'h004, 0);
      ev = (stamp[t] == 16'h0) ? 16'h0 : stamp[t] + 16'(t + 1);
      chk("stamp", {16'h0, ev}, rd);
    end
    // every mode but wake, captures counted from mode entry
    for (int m = 0; m < 7; m++)
    begin
      apb(1, 12'h000, 0);
      apb(1, 12'h000, ctl(0, 7, 0, capture_mode_t'(m)));
      pm.pulse(pl[m]);
      drain(n);
      chk("captures", ex[m], 32'(n));
    end
    // five edges into a four-deep buffer
    apb(1, 12'h000, ctl(0, 7, 0, MODE_RISE));
    pm.pulse(5);
    apb(0, 12'h000, 0);
    chk("overflow", ctl(0, 7, 0, MODE_RISE) | 32'h18, rd);
    drain(n);
    chk("drained", 32'h4, 32'(n));
    apb(1, 12'h000, ctl(0, 7, 0, MODE_RISE) | 32'h18);
    apb(0, 12'h000, 0);
    chk("flags ro", ctl(0, 7, 0, MODE_RISE), rd);
    // interrupt cadence for each captures-per-interrupt code
    for (int k = 0; k < 4; k++)
    begin
      apb(1, 12'h000, 0);
      apb(1, 12'h000, ctl(0, 7, k[1:0], MODE_RISE));
      base = irqCount;
      pm.pulse(k + 1);
      chk("irq cadence", 32'h1, 32'(irqCount - base));
      drain(n);
    end
    apb(1, 12'h000, ctl(0, 7, 3, MODE_BOTH));
    base = irqCount;
    pm.pulse(1);
    chk("irq both", 32'h2, 32'(irqCount - base));
    drain(n);
    // idle stop set, then clear
    apb(1, 12'h000, ctl(1, 7, 0, MODE_RISE));
    cpuIdle <= 1'b1;
    pm.pulse(1);
    drain(n);
    chk("idle halt", 32'h0, 32'(n));
    apb(1, 12'h000, ctl(0, 7, 0, MODE_RISE));
    pm.pulse(1);
    drain(n);
    chk("idle run", 32'h1, 32'(n));
    cpuIdle <= 1'b0;
    // wake pin: no irq while awake, one irq while asleep, nothing stored
    apb(1, 12'h000, ctl(0, 7, 0, MODE_WAKE));
    base = irqCount;
    pm.pulse(1);
    chk("wake awake", 32'h0, 32'(irqCount - base));
    cpuSleep <= 1'b1;
    pm.pulse(1);
    chk("wake sleep", 32'h1, 32'(irqCount - base));
    drain(n);
    chk("wake store", 32'h0, 32'(n));
    results();
  end
endmodule // input_capture_control_tb
